/* File: pkg/bdc_pkg.sv */
// shared constants and types of the background debug command engine
package bdc_pkg;

	// ----------------------------------------
	// command codes, as delivered by the serial deframer
	// ----------------------------------------
	localparam logic [3:0] BDC_CMD_NOP                = 4'h0;
	localparam logic [3:0] BDC_CMD_DATA_REG_READ_CMD  = 4'h1;
	localparam logic [3:0] BDC_CMD_ADDR_REG_READ_CMD  = 4'h2;
	localparam logic [3:0] BDC_CMD_DATA_REG_WRITE_CMD = 4'h3;
	localparam logic [3:0] BDC_CMD_ADDR_REG_WRITE_CMD = 4'h4;
	localparam logic [3:0] BDC_CMD_SYS_REG_READ_CMD   = 4'h5;
	localparam logic [3:0] BDC_CMD_SYS_REG_WRITE_CMD  = 4'h6;
	localparam logic [3:0] BDC_CMD_MEM_READ           = 4'h7;
	localparam logic [3:0] BDC_CMD_MEM_WRITE          = 4'h8;
	localparam logic [3:0] BDC_CMD_BLOCK_READ         = 4'h9;
	localparam logic [3:0] BDC_CMD_BLOCK_WRITE        = 4'hA;
	localparam logic [3:0] BDC_CMD_RESUME             = 4'hB;
	localparam logic [3:0] BDC_CMD_PATCH              = 4'hC;
	localparam logic [3:0] BDC_CMD_PERIPH_RESET       = 4'hD;

	// ----------------------------------------
	// operand sizes and address spaces
	// ----------------------------------------
	localparam logic [1:0]  BDC_SZ_BYTE     = 2'h0;
	localparam logic [1:0]  BDC_SZ_WORD     = 2'h1;
	localparam logic [1:0]  BDC_SZ_LONG     = 2'h2;
	localparam logic [31:0] BDC_BYTES_BYTE  = 32'h1;
	localparam logic [31:0] BDC_BYTES_WORD  = 32'h2;
	localparam logic [31:0] BDC_BYTES_LONG  = 32'h4;
	localparam logic [2:0]  BDC_FC_SUP_DATA = 3'h5;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int BDC_PERIPH_RESET_CYCLES = 512;

	// ----------------------------------------
	// engine states
	// ----------------------------------------
	typedef enum logic [6:0] {
		BDC_ST_IDLE  = 7'b0000001,
		BDC_ST_REG   = 7'b0000010,
		BDC_ST_MEM   = 7'b0000100,
		BDC_ST_PUSH  = 7'b0001000,
		BDC_ST_FLUSH = 7'b0010000,
		BDC_ST_RESP  = 7'b0100000,
		BDC_ST_SPARE = 7'b1000000
	} bdc_state_e;

endpackage

/* File: hw/bdc_resp_buf.sv */
// two-entry response buffer with valid and ready on both sides
`timescale 1ns/1ps
module bdc_resp_buf #(
	parameter int WIDTH = 33
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	// ----------------------------------------
	// storage: head register feeds the port directly
	// ----------------------------------------
	logic [WIDTH-1:0] tail;
	logic             tail_valid;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// ready comes from a flop so the source never sees a combinational path
	assign in_ready = !tail_valid;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_valid  <= 1'b0;
			out_data   <= '0;
			tail       <= '0;
			tail_valid <= 1'b0;
		end else begin
			if (pop || !out_valid) begin
				out_valid  <= tail_valid || push;
				out_data   <= tail_valid ? tail : in_data;
				tail_valid <= tail_valid && push;
				tail       <= in_data;
			end else if (push) begin
				tail       <= in_data;
				tail_valid <= 1'b1;
			end
		end
	end
endmodule

/* File: hw/bdc_reset_timer.sv */
// fixed-length pulse generator for the peripheral reset line
`timescale 1ns/1ps
module bdc_reset_timer #(
	parameter int CYCLES = 512
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      active
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;

	// a new start while running restarts the full length
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			active <= 1'b0;
			count  <= '0;
		end else if (start) begin
			active <= 1'b1;
			count  <= '0;
		end else if (active) begin
			active <= (count != LAST);
			count  <= count + CW'(1);
		end
	end
endmodule

/* File: hw/bdc_engine.sv */
// command execution engine for background debug mode
`timescale 1ns/1ps
// ----------------------------------------
// Summary of operation
// R01: register read returns data or address register
// R02: register write loads host operand
// R03: system register read returns supervisor register
// R04: system register write stores host operand
// R05: memory read returns sized datum at address
// R06: memory read space from source select
// R07: memory write stores operand at address
// R08: memory write space from destination select
// R09: block read continues after initial memory read
// R10: block write continues after initial memory write
// R11: resume flushes pipe, continues at pc
// R12: patch pushes pc, jumps to patch code
// R13: peripheral reset held 512 cycles
// R14: peripheral reset leaves core running state alone
// R15: null command changes nothing
// R16: block address advances by operand size
// R17: only when halted; unknown code errors
// ----------------------------------------
module bdc_engine
	import bdc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        core_halted,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [3:0]  cmd_code,
	input  wire logic [3:0]  cmd_reg,
	input  wire logic [1:0]  cmd_size,
	input  wire logic [31:0] cmd_addr,
	input  wire logic [31:0] cmd_data,
	output logic             rsp_valid,
	input  wire logic        rsp_ready,
	output logic [31:0]      rsp_data,
	output logic             rsp_err,
	output logic             reg_req,
	output logic             reg_we,
	output logic             reg_sys,
	output logic [3:0]       reg_idx,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_ack,
	input  wire logic [2:0]  source_space_select,
	input  wire logic [2:0]  destination_space_select,
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output logic [1:0]       mem_size,
	output logic [2:0]       mem_fc,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] core_pc,
	input  wire logic [31:0] core_sp,
	output logic             core_flush,
	output logic             core_resume,
	output logic             load_pc,
	output logic [31:0]      load_pc_value,
	output logic [31:0]      load_sp_value,
	output logic             periph_reset
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	bdc_state_e  state;
	logic [31:0] blk_addr;
	logic [1:0]  blk_size;
	logic [31:0] call_addr;
	logic [31:0] rsp_word;
	logic        rsp_bad;
	logic        rst_start;
	logic        buf_ready;

	wire fire      = cmd_valid && cmd_ready;
	wire is_dreg_r = cmd_code == BDC_CMD_DATA_REG_READ_CMD;
	wire is_areg_r = cmd_code == BDC_CMD_ADDR_REG_READ_CMD;
	wire is_dreg_w = cmd_code == BDC_CMD_DATA_REG_WRITE_CMD;
	wire is_areg_w = cmd_code == BDC_CMD_ADDR_REG_WRITE_CMD;
	wire is_sys_r  = cmd_code == BDC_CMD_SYS_REG_READ_CMD;
	wire is_sys_w  = cmd_code == BDC_CMD_SYS_REG_WRITE_CMD;
	wire is_rd     = cmd_code == BDC_CMD_MEM_READ;
	wire is_wr     = cmd_code == BDC_CMD_MEM_WRITE;
	wire is_brd    = cmd_code == BDC_CMD_BLOCK_READ;
	wire is_bwr    = cmd_code == BDC_CMD_BLOCK_WRITE;
	wire is_go     = cmd_code == BDC_CMD_RESUME;
	wire is_call   = cmd_code == BDC_CMD_PATCH;
	wire is_prst   = cmd_code == BDC_CMD_PERIPH_RESET;
	wire is_nop    = cmd_code == BDC_CMD_NOP;
	wire is_regop  = is_dreg_r || is_areg_r || is_dreg_w || is_areg_w || is_sys_r || is_sys_w;
	wire is_memop  = is_rd || is_wr || is_brd || is_bwr;
	wire is_wrop   = is_wr || is_bwr;
	wire known     = is_regop || is_memop || is_go || is_call || is_prst || is_nop;
	// not halted or unknown code both answer with an error word
	wire refuse    = !core_halted || !known; // R17

	// address and register selection
	wire [3:0]  next_reg_idx = (is_sys_r || is_sys_w) ? cmd_reg
		: {(is_areg_r || is_areg_w), cmd_reg[2:0]}; // R01 R02 R03 R04
	wire [31:0] next_addr    = (is_brd || is_bwr) ? blk_addr : cmd_addr; // R09 R10
	wire [1:0]  next_size    = (is_brd || is_bwr) ? blk_size : cmd_size;
	wire [2:0]  next_fc      = is_wrop ? destination_space_select
		: source_space_select; // R06 R08
	wire [31:0] size_bytes   = (mem_size == BDC_SZ_BYTE) ? BDC_BYTES_BYTE
		: (mem_size == BDC_SZ_WORD) ? BDC_BYTES_WORD : BDC_BYTES_LONG;
	wire [31:0] push_addr    = core_sp - BDC_BYTES_LONG;
	wire        resp_push    = (state == BDC_ST_RESP);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state         <= BDC_ST_IDLE;
			cmd_ready     <= 1'b0;
			reg_req       <= 1'b0;
			reg_we        <= 1'b0;
			reg_sys       <= 1'b0;
			reg_idx       <= '0;
			reg_wdata     <= '0;
			mem_req       <= 1'b0;
			mem_we        <= 1'b0;
			mem_addr      <= '0;
			mem_size      <= '0;
			mem_fc        <= '0;
			mem_wdata     <= '0;
			blk_addr      <= '0;
			blk_size      <= '0;
			call_addr     <= '0;
			core_flush    <= 1'b0;
			core_resume   <= 1'b0;
			load_pc       <= 1'b0;
			load_pc_value <= '0;
			load_sp_value <= '0;
			rsp_word      <= '0;
			rsp_bad       <= 1'b0;
			rst_start     <= 1'b0;
		end else begin
			core_flush  <= 1'b0;
			core_resume <= 1'b0;
			load_pc     <= 1'b0;
			rst_start   <= 1'b0;
			case (state)
				BDC_ST_IDLE: begin
					cmd_ready <= !fire;
					rsp_word  <= '0;
					rsp_bad   <= 1'b0;
					if (fire) begin
						state <= BDC_ST_RESP;
						if (refuse) begin
							rsp_bad <= 1'b1; // R17
						end else if (is_regop) begin
							reg_req   <= 1'b1; // R01 R02 R03 R04
							reg_we    <= is_dreg_w || is_areg_w || is_sys_w;
							reg_sys   <= is_sys_r || is_sys_w;
							reg_idx   <= next_reg_idx;
							reg_wdata <= cmd_data;
							state     <= BDC_ST_REG;
						end else if (is_memop) begin
							mem_req   <= 1'b1; // R05 R07
							mem_we    <= is_wrop;
							mem_addr  <= next_addr;
							mem_size  <= next_size;
							mem_fc    <= next_fc; // R06 R08
							mem_wdata <= cmd_data;
							blk_size  <= next_size;
							state     <= BDC_ST_MEM;
						end else if (is_go) begin
							core_flush <= 1'b1; // R11
							state      <= BDC_ST_FLUSH;
						end else if (is_call) begin
							mem_req   <= 1'b1; // R12
							mem_we    <= 1'b1;
							mem_addr  <= push_addr;
							mem_size  <= BDC_SZ_LONG;
							mem_fc    <= BDC_FC_SUP_DATA;
							mem_wdata <= core_pc;
							call_addr <= cmd_addr;
							state     <= BDC_ST_PUSH;
						end else if (is_prst) begin
							rst_start <= 1'b1; // R13 R14
						end
						// null command falls through to an empty answer R15
					end
				end
				BDC_ST_REG: begin
					if (reg_ack) begin
						reg_req  <= 1'b0;
						rsp_word <= reg_we ? '0 : reg_rdata; // R01 R03
						state    <= BDC_ST_RESP;
					end
				end
				BDC_ST_MEM: begin
					if (mem_ack) begin
						mem_req  <= 1'b0;
						rsp_word <= mem_we ? '0 : mem_rdata; // R05
						blk_addr <= mem_addr + size_bytes; // R16
						state    <= BDC_ST_RESP;
					end
				end
				BDC_ST_PUSH: begin
					if (mem_ack) begin
						mem_req       <= 1'b0;
						load_pc       <= 1'b1; // R12
						load_pc_value <= call_addr;
						load_sp_value <= mem_addr;
						state         <= BDC_ST_RESP;
					end
				end
				BDC_ST_FLUSH: begin
					core_resume <= 1'b1; // R11
					state       <= BDC_ST_RESP;
				end
				BDC_ST_RESP: begin
					// answer waits here while both response buffer entries are full
					if (buf_ready) begin
						cmd_ready <= 1'b1;
						state     <= BDC_ST_IDLE;
					end
				end
				default: begin
					state <= BDC_ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// answer path and peripheral reset
	// ----------------------------------------
	bdc_resp_buf #(
		.WIDTH (33)
	) u_resp_buf (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (resp_push),
		.in_ready  (buf_ready),
		.in_data   ({rsp_bad, rsp_word}),
		.out_valid (rsp_valid),
		.out_ready (rsp_ready),
		.out_data  ({rsp_err, rsp_data})
	);

	// core state is untouched; only the external line pulses
	bdc_reset_timer #(
		.CYCLES (BDC_PERIPH_RESET_CYCLES)
	) u_reset_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (rst_start), // R13 R14
		.active  (periph_reset)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [9:0] hi_cnt;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= '0;
		end else begin
			// a re-issue restarts the pulse, so the length count restarts too
			hi_cnt <= (periph_reset && !rst_start) ? hi_cnt + 10'h001 : 10'h000;
		end
	end

	property p_reset_len;
		@(posedge ref_clk) disable iff (rst)
		$fell(periph_reset) |-> hi_cnt == 10'(BDC_PERIPH_RESET_CYCLES);
	endproperty
	a_reset_len: assert property (p_reset_len) else $error("reset pulse length wrong"); // R13

	property p_reset_start;
		@(posedge ref_clk) disable iff (rst)
		fire && !refuse && is_prst |-> ##2 periph_reset;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("reset not started"); // R13

	property p_reset_core;
		@(posedge ref_clk) disable iff (rst)
		fire && !refuse && is_prst |=> !core_flush && !load_pc && state == BDC_ST_RESP;
	endproperty
	a_reset_core: assert property (p_reset_core) else $error("reset touched core"); // R14

	property p_read_space;
		@(posedge ref_clk) disable iff (rst)
		fire && !refuse && (is_rd || is_brd) |=>
			mem_req && !mem_we && mem_fc == $past(source_space_select);
	endproperty
	a_read_space: assert property (p_read_space) else $error("read space wrong"); // R06

	property p_write_space;
		@(posedge ref_clk) disable iff (rst)
		fire && !refuse && is_wrop |=>
			mem_req && mem_we && mem_fc == $past(destination_space_select)
			&& mem_wdata == $past(cmd_data);
	endproperty
	a_write_space: assert property (p_write_space) else $error("write space wrong"); // R08

	property p_blk_adv;
		@(posedge ref_clk) disable iff (rst)
		state == BDC_ST_MEM && mem_ack |=> blk_addr == $past(mem_addr) + $past(size_bytes);
	endproperty
	a_blk_adv: assert property (p_blk_adv) else $error("block address not advanced"); // R16

	property p_refuse;
		@(posedge ref_clk) disable iff (rst)
		fire && refuse |=> state == BDC_ST_RESP && rsp_bad && !reg_req && !mem_req;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused command not flagged"); // R17

	property p_resume;
		@(posedge ref_clk) disable iff (rst)
		fire && !refuse && is_go |=> core_flush ##1 (core_resume && !core_flush);
	endproperty
	a_resume: assert property (p_resume) else $error("resume order wrong"); // R11

	property p_patch;
		@(posedge ref_clk) disable iff (rst)
		state == BDC_ST_PUSH && mem_ack |=> load_pc && load_pc_value == call_addr
			&& load_sp_value == $past(mem_addr);
	endproperty
	a_patch: assert property (p_patch) else $error("patch entry wrong"); // R12

	property p_reg_write;
		@(posedge ref_clk) disable iff (rst)
		fire && !refuse && (is_dreg_w || is_areg_w) |=>
			reg_req && reg_we && !reg_sys && reg_wdata == $past(cmd_data);
	endproperty
	a_reg_write: assert property (p_reg_write) else $error("register write wrong"); // R02

	c_dump: cover property (@(posedge ref_clk) disable iff (rst)
		fire && is_brd && !refuse);
	c_call: cover property (@(posedge ref_clk) disable iff (rst) load_pc);
	c_stall: cover property (@(posedge ref_clk) disable iff (rst)
		resp_push && !buf_ready);
	c_prst: cover property (@(posedge ref_clk) disable iff (rst) $fell(periph_reset));
endmodule

/* File: tb/bdc_core_model.sv */
// core-side partner: register file and memory answering the engine
`timescale 1ns/1ps
module bdc_core_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        reg_req,
	input  wire logic        reg_we,
	input  wire logic        reg_sys,
	input  wire logic [3:0]  reg_idx,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	output logic             reg_ack,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic [31:0]      mem_rdata,
	output logic             mem_ack
);
	logic [31:0] regs [0:31];
	logic [31:0] mem [logic [31:0]];
	int          rc;
	int          mc;

	// ----------------------------------------
	// one ack pulse per held request, prompt or slow
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_ack <= 1'h0;
			mem_ack <= 1'h0;
			reg_rdata <= 32'h0;
			mem_rdata <= 32'h0;
			rc = 0;
			mc = 0;
		end else begin
			reg_ack <= 1'h0;
			mem_ack <= 1'h0;
			// toggled outside ack so stale data never looks valid
			reg_rdata <= ~reg_rdata;
			mem_rdata <= ~mem_rdata;
			if (reg_req && !reg_ack) begin
				rc = rc + 1;
				if (rc > (slow ? 3 : 0)) begin
					rc = 0;
					reg_ack <= 1'h1;
					if (reg_we)
						regs[{reg_sys, reg_idx}] = reg_wdata;
					else
						reg_rdata <= regs[{reg_sys, reg_idx}];
				end
			end
			if (mem_req && !mem_ack) begin
				mc = mc + 1;
				if (mc > (slow ? 3 : 0)) begin
					mc = 0;
					mem_ack <= 1'h1;
					if (mem_we)
						mem[mem_addr] = mem_wdata;
					else
						mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
				end
			end
		end
	end
endmodule

/* File: tb/tb_bdc_engine.sv */
// self-checking bench of the background debug command engine
`timescale 1ns/1ps
module tb_bdc_engine import bdc_pkg::*;;
	logic        ref_clk, rst, core_halted, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
	logic        rsp_err, slow, reg_req, reg_we, reg_sys, reg_ack, mem_req, mem_we;
	logic        mem_ack, core_flush, core_resume, load_pc, periph_reset, er;
	logic [3:0]  cmd_code, cmd_reg, reg_idx;
	logic [1:0]  cmd_size, mem_size;
	logic [2:0]  source_space_select, destination_space_select, mem_fc;
	logic [31:0] cmd_addr, cmd_data, rsp_data, reg_wdata, reg_rdata, mem_addr, mem_wdata;
	logic [31:0] mem_rdata, core_pc, core_sp, load_pc_value, load_sp_value, rd, a, lp, ls;
	logic [31:0] q_addr[$], q_wd[$], dv[3];
	logic [2:0]  q_fc[$];
	logic [1:0]  q_sz[$];
	int          num_errors, checks, cyc, n_reg, n_flush, at_flush, at_resume, pr_run, pr_len;
	int          r, s0, s1;
	logic [3:0]  wcode[3] = '{BDC_CMD_DATA_REG_WRITE_CMD, BDC_CMD_ADDR_REG_WRITE_CMD,
		BDC_CMD_SYS_REG_WRITE_CMD};
	logic [3:0]  rcode[3] = '{BDC_CMD_DATA_REG_READ_CMD, BDC_CMD_ADDR_REG_READ_CMD,
		BDC_CMD_SYS_REG_READ_CMD};

	bdc_engine i_bdc_engine (.ref_clk, .rst, .core_halted, .cmd_valid, .cmd_ready, .cmd_code,
		.cmd_reg, .cmd_size, .cmd_addr, .cmd_data, .rsp_valid, .rsp_ready, .rsp_data, .rsp_err,
		.reg_req, .reg_we, .reg_sys, .reg_idx, .reg_wdata, .reg_rdata, .reg_ack,
		.source_space_select, .destination_space_select, .mem_req, .mem_we, .mem_addr,
		.mem_size, .mem_fc, .mem_wdata, .mem_rdata, .mem_ack, .core_pc, .core_sp, .core_flush,
		.core_resume, .load_pc, .load_pc_value, .load_sp_value, .periph_reset);
	bdc_core_model i_bdc_core_model (.ref_clk, .rst, .slow, .reg_req, .reg_we, .reg_sys,
		.reg_idx, .reg_wdata, .reg_rdata, .reg_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack);

	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// monitors of the core-side traffic
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cyc++;
		if (mem_req && mem_ack) begin
			q_addr.push_back(mem_addr);
			q_fc.push_back(mem_fc);
			q_sz.push_back(mem_size);
			q_wd.push_back(mem_wdata);
		end
		if (reg_req && reg_ack) n_reg++;
		if (core_flush) begin
			n_flush++;
			at_flush = cyc;
		end
		if (core_resume) at_resume = cyc;
		if (load_pc) begin
			lp = load_pc_value;
			ls = load_sp_value;
		end
		if (periph_reset) pr_run++;
		else if (pr_run != 0) begin
			pr_len = pr_run;
			pr_run = 0;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// host stalls its response side at random to exercise the buffer
	task automatic run(input logic [3:0] c, input logic [3:0] rg, input logic [1:0] sz,
		input logic [31:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		cmd_code <= c;
		cmd_reg <= rg;
		cmd_size <= sz;
		cmd_addr <= ad;
		cmd_data <= d;
		cmd_valid <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!cmd_ready && n < 100);
		cmd_valid <= 1'h0;
		rsp_ready <= 1'($urandom_range(0, 1));
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			if (!(rsp_valid && rsp_ready)) rsp_ready <= 1'($urandom_range(0, 1));
		end while (!(rsp_valid && rsp_ready) && n < 200);
		rd = rsp_data;
		er = rsp_err;
		rsp_ready <= 1'h0;
		check("response arrived", {31'h0, n < 200}, 32'h1);
	endtask

	initial begin
		#500000;
		num_errors++;
		report_and_stop();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		r = $urandom(32'hA4CFCB8F);
		{rst, core_halted, cmd_valid, rsp_ready, slow} = 5'h18;
		{cmd_code, cmd_reg, cmd_size, cmd_addr, cmd_data} = '0;
		core_pc = $urandom;
		core_sp = $urandom;
		s0 = $urandom_range(0, 3);
		source_space_select = 3'(s0);
		destination_space_select = 3'(s0 + 4);
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		repeat (2) @(posedge ref_clk);
		r = $urandom_range(0, 7);
		for (int p = 0; p < 2; p++) begin
			slow <= 1'(p);
			for (int k = 0; k < 3; k++) begin
				dv[k] = $urandom;
				run(wcode[k], 4'(r), BDC_SZ_LONG, 32'h0, dv[k]);
				check("write answer", rd, 32'h0);
			end
			for (int k = 0; k < 3; k++) begin
				run(rcode[k], 4'(r), BDC_SZ_LONG, 32'h0, 32'h0);
				check("register read", rd, dv[k]);
			end
		end
		// long block: write then fill, read then dump
		a = $urandom & 32'hFFFFFFF0;
		q_addr.delete();
		q_fc.delete();
		q_wd.delete();
		for (int k = 0; k < 3; k++) begin
			dv[k] = $urandom;
			run(k == 0 ? BDC_CMD_MEM_WRITE : BDC_CMD_BLOCK_WRITE, 4'h0,
				k == 0 ? BDC_SZ_LONG : BDC_SZ_BYTE, a, dv[k]);
		end
		for (int k = 0; k < 3; k++) begin
			run(k == 0 ? BDC_CMD_MEM_READ : BDC_CMD_BLOCK_READ, 4'h0, BDC_SZ_LONG, a, 32'h0);
			check("memory read", rd, dv[k]);
		end
		for (int i = 0; i < 6; i++) begin
			check("block address", q_addr[i], a + 32'(4 * (i % 3)));
			check("space", {29'h0, q_fc[i]}, 32'(i < 3 ? s0 + 4 : s0));
			if (i < 3) check("write data", q_wd[i], dv[i]);
		end
		// block step follows the size of the opening access
		for (int k = 0; k < 2; k++) begin
			q_addr.delete();
			q_sz.delete();
			run(BDC_CMD_MEM_READ, 4'h0, k == 0 ? BDC_SZ_BYTE : BDC_SZ_WORD, a, 32'h0);
			run(BDC_CMD_BLOCK_READ, 4'h0, BDC_SZ_LONG, 32'h0, 32'h0);
			check("step", q_addr[1], a + 32'(k + 1));
			check("step size", {30'h0, q_sz[1]}, {30'h0, k == 0 ? BDC_SZ_BYTE : BDC_SZ_WORD});
		end
		s1 = n_flush;
		run(BDC_CMD_RESUME, 4'h0, BDC_SZ_LONG, 32'h0, 32'h0);
		check("flush count", 32'(n_flush), 32'(s1 + 1));
		check("resume after flush", 32'(at_resume), 32'(at_flush + 1));
		q_addr.delete();
		q_fc.delete();
		q_wd.delete();
		a = $urandom;
		run(BDC_CMD_PATCH, 4'h0, BDC_SZ_LONG, a, 32'h0);
		check("push address", q_addr[0], core_sp - 32'h4);
		check("push space", {29'h0, q_fc[0]}, {29'h0, BDC_FC_SUP_DATA});
		check("pushed pc", q_wd[0], core_pc);
		check("patch entry", lp, a);
		check("new stack", ls, core_sp - 32'h4);
		s1 = n_flush;
		run(BDC_CMD_PERIPH_RESET, 4'h0, BDC_SZ_LONG, 32'h0, 32'h0);
		check("reset answer", {31'h0, er}, 32'h0);
		repeat (530) @(posedge ref_clk);
		check("reset length", 32'(pr_len), 32'(BDC_PERIPH_RESET_CYCLES));
		check("core untouched", 32'(n_flush), 32'(s1));
		// null, refused and unknown commands make no register or memory access
		s0 = n_reg;
		s1 = q_addr.size();
		run(BDC_CMD_NOP, 4'h0, BDC_SZ_LONG, 32'h0, 32'h0);
		check("null answer", {er, rd[30:0]}, 32'h0);
		core_halted <= 1'h0;
		run(BDC_CMD_DATA_REG_WRITE_CMD, 4'(r), BDC_SZ_LONG, 32'h0, ~dv[0]);
		check("not halted", {31'h0, er}, 32'h1);
		core_halted <= 1'h1;
		for (int k = 14; k < 16; k++) begin
			run(4'(k), 4'(r), BDC_SZ_LONG, a, 32'h0);
			check("unknown code", {31'h0, er}, 32'h1);
		end
		check("no register access", 32'(n_reg), 32'(s0));
		check("no memory access", 32'(q_addr.size()), 32'(s1));
		report_and_stop();
	end
endmodule
